// ---- core/prot_checker.sv ----
// Purpose: physical memory protection checker for one hart
// Assumes: csr and access requests come from core-clock logic
// Notes:   verdicts and csr answers appear one cycle after request
//
// Summary of operation
// - eight entries, 64-byte minimum granule
// - lowest matching entry index decides
// - machine allowed by default, others denied
// - user always checked, machine only locked
// - modify_privilege with user mpp checks data as user
// - page walks checked as supervisor accesses
// - low config csr holds all; upper reads zero
// - odd config csrs raise illegal instruction
// - entry registers writable from machine mode only
// - locked entry ignores writes until reset
// - lock extends permissions onto machine mode
// - field: r0 w1 x2 mode4:3 lock7
// - mode: off, top, and two codes both matched as power-of-two
// - disabled entry never matches or protects
// - write-only permission unsupported, software avoids
// - reset clears mode and lock fields
// - top mode: previous address up to own
// - trailing ones encode power-of-two size
// - address register holds address shifted two
// - partial entry coverage fails the access
// - denial gives load, store or fetch fault
module prot_checker
  import prot_pkg::*;
#(
  parameter int ENTRIES = NUM_ENTRIES
) (
  // clock and reset
  input  wire logic            mclk,
  input  wire logic            nrst,
  input  wire logic            clkEn,
  // csr port
  input  wire logic            csrValid,
  input  wire logic            csrWrite,
  input  wire logic [11:0]     csrAddr,
  input  wire logic [XLEN-1:0] csrWdata,
  input  wire logic [1:0]      csrPriv,
  output logic                 csrDone_r,
  output logic                 csrIllegal_r,
  output logic [XLEN-1:0]      csrRdata_r,
  // privilege state
  input  wire logic [1:0]      previousPrivilege,
  input  wire logic            modifyPrivilege,
  // access check port
  input  wire logic            accValid,
  input  wire logic [1:0]      accType,
  input  wire logic [1:0]      accSize,
  input  wire logic [PA_W-1:0] accAddr,
  input  wire logic [1:0]      accPriv,
  input  wire logic            accPtw,
  output logic                 accDone_r,
  output logic                 accDeny_r,
  output logic                 loadFault_r,
  output logic                 storeFault_r,
  output logic                 fetchFault_r
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rstSync_r;
  logic       rstN;

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rstSync_r <= 2'b00;
    end else begin
      rstSync_r <= {rstSync_r[0], 1'b1};
    end
  end

  assign rstN = rstSync_r[1];

  // ----------------------------------------------------------------
  // entry registers and csr path
  // ----------------------------------------------------------------
  logic [CFG_W-1:0]  cfg_r   [ENTRIES];
  logic [CFG_W-1:0]  cfg_nxt [ENTRIES];
  logic [ADDR_W-1:0] addr_r  [ENTRIES];
  logic [ADDR_W-1:0] addr_nxt[ENTRIES];
  logic              csrDone_nxt;
  logic              csrIllegal_nxt;
  logic [XLEN-1:0]   csrRdata_nxt;
  logic [IDX_W-1:0]  csrIdx;
  logic [ADDR_W-1:0] gran;
  logic [ADDR_W-1:0] readBack;

  always_comb begin
    gran           = ADDR_W'((1 << GRAN_W) - 1);
    csrIdx         = csrAddr[IDX_W-1:0];
    readBack       = '0;
    cfg_nxt        = cfg_r;
    addr_nxt       = addr_r;
    csrDone_nxt    = 1'b0;
    csrIllegal_nxt = 1'b0;
    csrRdata_nxt   = '0;
    if (csrValid) begin
      if ((csrAddr >= CSR_CFG_LOW && csrAddr <= CSR_CFG_ODD3) ||
          (csrAddr >= CSR_ADDR_BASE && csrAddr <= CSR_ADDR_LAST)) begin
        csrDone_nxt = 1'b1;
      end
      if (!csrDone_nxt) begin
        csrIllegal_nxt = 1'b0;
      end else if (csrPriv != PRIV_M) begin
        csrIllegal_nxt = 1'b1;
      end else if (csrAddr == CSR_CFG_ODD1 ||
                   csrAddr == CSR_CFG_ODD3) begin
        csrIllegal_nxt = 1'b1;
      end else if (csrAddr == CSR_CFG_LOW) begin
        for (int i = 0; i < ENTRIES; i++) begin
          csrRdata_nxt[i*CFG_W +: CFG_W] = cfg_r[i];
          if (csrWrite && !cfg_r[i][CFG_L]) begin
            cfg_nxt[i] = csrWdata[i*CFG_W +: CFG_W];
          end
        end
      end else if (csrAddr == CSR_CFG_HIGH) begin
        csrRdata_nxt = '0;
      end else begin
        readBack = addr_r[csrIdx];
        if (cfg_r[csrIdx][CFG_A_HI]) begin
          readBack = readBack | (gran >> 1);
        end else begin
          readBack = readBack & ~gran;
        end
        csrRdata_nxt = XLEN'(readBack);
        if (csrWrite && !cfg_r[csrIdx][CFG_L]) begin
          addr_nxt[csrIdx] = csrWdata[ADDR_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      for (int i = 0; i < ENTRIES; i++) begin
        cfg_r[i]  <= CFG_RESET;
        addr_r[i] <= '0;
      end
      csrDone_r    <= 1'b0;
      csrIllegal_r <= 1'b0;
      csrRdata_r   <= '0;
    end else if (clkEn) begin
      cfg_r        <= cfg_nxt;
      addr_r       <= addr_nxt;
      csrDone_r    <= csrDone_nxt;
      csrIllegal_r <= csrIllegal_nxt;
      csrRdata_r   <= csrRdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // parallel entry matching
  // ----------------------------------------------------------------
  logic [PA_W-1:0]   accLast;
  logic [ADDR_W-1:0] firstWord;
  logic [ADDR_W-1:0] lastWord;
  logic [ENTRIES-1:0] firstIn;
  logic [ENTRIES-1:0] lastIn;
  logic [ENTRIES-1:0] hit;

  always_comb begin
    accLast   = accAddr + PA_W'((1 << accSize) - 1);
    firstWord = accAddr[PA_W-1:WORD_SHIFT];
    lastWord  = accLast[PA_W-1:WORD_SHIFT];
  end

  for (genvar g = 0; g < ENTRIES; g++) begin : gEntry
    logic [ADDR_W-1:0] prevReg;
    if (g == 0) begin : gFirst
      assign prevReg = '0;
    end else begin : gRest
      assign prevReg = addr_r[g-1];
    end
    prot_entry_match #(
      .AW (ADDR_W),
      .GW (GRAN_W)
    ) uMatch (
      .mode      (cfg_r[g][CFG_A_HI:CFG_A_LO]),
      .addrReg   (addr_r[g]),
      .prevReg   (prevReg),
      .firstWord (firstWord),
      .lastWord  (lastWord),
      .firstIn   (firstIn[g]),
      .lastIn    (lastIn[g])
    );
    // disabled entries drop out of matching
    assign hit[g] = (cfg_r[g][CFG_A_HI:CFG_A_LO] != MODE_OFF) &&
                    (firstIn[g] || lastIn[g]);
    AST_LOCK_HOLDS:
      assert property (@(posedge mclk) disable iff (!rstN)
        cfg_r[g][CFG_L] |=> cfg_r[g][CFG_L] && $stable(addr_r[g]) &&
        $stable(cfg_r[g]))
      else $error("locked entry was modified");
  end

  // ----------------------------------------------------------------
  // verdict
  // ----------------------------------------------------------------
  logic [1:0] effPriv;
  logic       deny;
  logic       accDone_nxt;
  logic       accDeny_nxt;
  logic       loadFault_nxt;
  logic       storeFault_nxt;
  logic       fetchFault_nxt;

  always_comb begin
    effPriv = accPriv;
    if (accPtw) begin
      effPriv = PRIV_S;
    end else if (modifyPrivilege && accType != ACC_FETCH &&
                 accPriv == PRIV_M) begin
      effPriv = previousPrivilege;
    end
    deny = (effPriv != PRIV_M);
    // walk downwards so the lowest hit index is applied last
    for (int i = ENTRIES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        if (firstIn[i] != lastIn[i]) begin
          deny = 1'b1;
        end else if (effPriv == PRIV_M && !cfg_r[i][CFG_L]) begin
          deny = 1'b0;
        end else begin
          deny = !cfg_r[i][accType];
        end
      end
    end
    accDone_nxt    = accValid;
    accDeny_nxt    = accValid && deny;
    loadFault_nxt  = accDeny_nxt && accType == ACC_LOAD;
    storeFault_nxt = accDeny_nxt && accType == ACC_STORE;
    fetchFault_nxt = accDeny_nxt && accType == ACC_FETCH;
  end

  always_ff @(posedge mclk or negedge rstN) begin
    if (!rstN) begin
      accDone_r    <= 1'b0;
      accDeny_r    <= 1'b0;
      loadFault_r  <= 1'b0;
      storeFault_r <= 1'b0;
      fetchFault_r <= 1'b0;
    end else if (clkEn) begin
      accDone_r    <= accDone_nxt;
      accDeny_r    <= accDeny_nxt;
      loadFault_r  <= loadFault_nxt;
      storeFault_r <= storeFault_nxt;
      fetchFault_r <= fetchFault_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_M_DEFAULT_ALLOW:
    assert property (@(posedge mclk) disable iff (!rstN)
      clkEn && accValid && !accPtw && !modifyPrivilege &&
      accPriv == PRIV_M && hit == '0 |=> accDone_r && !accDeny_r)
    else $error("machine access without hit was denied");

  AST_U_DEFAULT_DENY:
    assert property (@(posedge mclk) disable iff (!rstN)
      clkEn && accValid && accPriv == PRIV_U && hit == '0
      |=> accDeny_r)
    else $error("user access without hit was allowed");

  AST_ODD_CFG_ILLEGAL:
    assert property (@(posedge mclk) disable iff (!rstN)
      clkEn && csrValid &&
      (csrAddr == CSR_CFG_ODD1 || csrAddr == CSR_CFG_ODD3)
      |=> csrDone_r && csrIllegal_r)
    else $error("odd config csr did not trap");

  AST_LOW_PRIV_NO_WRITE:
    assert property (@(posedge mclk) disable iff (!rstN)
      clkEn && csrValid && csrWrite && csrPriv != PRIV_M &&
      ((csrAddr >= CSR_CFG_LOW && csrAddr <= CSR_CFG_ODD3) ||
       (csrAddr >= CSR_ADDR_BASE && csrAddr <= CSR_ADDR_LAST))
      |=> $stable(cfg_r[0]) && $stable(addr_r[0]) && csrIllegal_r)
    else $error("entry state changed by non-machine write");

  AST_HIGH_CFG_ZERO:
    assert property (@(posedge mclk) disable iff (!rstN)
      clkEn && csrValid && csrPriv == PRIV_M &&
      csrAddr == CSR_CFG_HIGH |=> csrRdata_r == '0 && !csrIllegal_r)
    else $error("upper config csr read nonzero");

  AST_OFF_NO_HIT:
    assert property (@(posedge mclk) disable iff (!rstN)
      clkEn && accValid && !accPtw && !modifyPrivilege &&
      cfg_r[0][CFG_A_HI:CFG_A_LO] == MODE_OFF && hit[ENTRIES-1:1] == '0
      |=> accDeny_r == ($past(accPriv) != PRIV_M))
    else $error("disabled entry changed a verdict");

  AST_FAULT_KIND:
    assert property (@(posedge mclk) disable iff (!rstN)
      clkEn && accValid && deny && accType == ACC_STORE
      |=> storeFault_r && !loadFault_r && !fetchFault_r)
    else $error("store denial gave wrong fault kind");

  AST_ENTRY0_WINS:
    assert property (@(posedge mclk) disable iff (!rstN)
      clkEn && accValid && hit[0] && firstIn[0] && lastIn[0] &&
      (accPriv == PRIV_U) && !accPtw && cfg_r[0][accType]
      |=> !accDeny_r)
    else $error("entry zero grant was overridden");

endmodule // prot_checker

// ---- core/prot_pkg.sv ----
// Purpose: shared constants for the memory protection checker
// Assumes: 64-bit CSRs, 56-bit physical addresses
// Notes:   CSR numbers follow the standard protection CSR block
package prot_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_ENTRIES = 8;
  localparam int XLEN        = 64;
  localparam int PA_W        = 56;
  localparam int ADDR_W      = 54;       // word address bits [55:2]
  localparam int WORD_SHIFT  = 2;
  localparam int GRAN_W      = 4;        // log2 of the 64-byte granule in words
  localparam int CFG_W       = 8;
  localparam int IDX_W       = 3;

  // ----------------------------------------------------------------
  // csr numbers
  // ----------------------------------------------------------------
  localparam logic [11:0] CSR_CFG_LOW   = 12'h3a0;
  localparam logic [11:0] CSR_CFG_ODD1  = 12'h3a1;
  localparam logic [11:0] CSR_CFG_HIGH  = 12'h3a2;
  localparam logic [11:0] CSR_CFG_ODD3  = 12'h3a3;
  localparam logic [11:0] CSR_ADDR_BASE = 12'h3b0;
  localparam logic [11:0] CSR_ADDR_LAST = 12'h3b7;

  // ----------------------------------------------------------------
  // configuration field layout
  // ----------------------------------------------------------------
  localparam int CFG_R    = 0;
  localparam int CFG_W_B  = 1;
  localparam int CFG_X    = 2;
  localparam int CFG_A_LO = 3;
  localparam int CFG_A_HI = 4;
  localparam int CFG_L    = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;

  typedef enum logic [1:0] {
    MODE_OFF   = 2'b00,
    MODE_TOR   = 2'b01,
    MODE_NA4   = 2'b10,
    MODE_POWER_OF_TWO_MODE = 2'b11
  } prot_mode_t;

  typedef enum logic [1:0] {
    PRIV_U = 2'b00,
    PRIV_S = 2'b01,
    PRIV_M = 2'b11
  } prot_priv_t;

  // encoding equals the permission bit position in a config field
  typedef enum logic [1:0] {
    ACC_LOAD  = 2'b00,
    ACC_STORE = 2'b01,
    ACC_FETCH = 2'b10
  } prot_acc_t;

endpackage

// ---- core/prot_entry_match.sv ----
// Purpose: address range test for one protection entry
// Assumes: word addresses, granule set by GW
// Notes:   reports first and last byte of an access separately
module prot_entry_match
  import prot_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int GW = GRAN_W
) (
  // entry settings
  input  wire logic [1:0]    mode,
  input  wire logic [AW-1:0] addrReg,
  input  wire logic [AW-1:0] prevReg,
  // access bounds
  input  wire logic [AW-1:0] firstWord,
  input  wire logic [AW-1:0] lastWord,
  // result
  output logic               firstIn,
  output logic               lastIn
);

  logic [AW-1:0] gran;
  logic [AW-1:0] topW;
  logic [AW-1:0] botW;
  logic [AW-1:0] napX;
  logic [AW-1:0] napMask;

  function automatic logic inRange(input logic [1:0]    m,
                                   input logic [AW-1:0] w,
                                   input logic [AW-1:0] lo,
                                   input logic [AW-1:0] hi,
                                   input logic [AW-1:0] x,
                                   input logic [AW-1:0] msk);
    logic r;
    r = 1'b0;
    case (m)
      MODE_TOR:   r = (w >= lo) && (w < hi);
      MODE_NA4,
      MODE_POWER_OF_TWO_MODE: r = (w & msk) == (x & msk);
      default:    r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb begin
    gran    = AW'((1 << GW) - 1);
    topW    = addrReg & ~gran;
    botW    = prevReg & ~gran;
    napX    = addrReg | (gran >> 1);
    napMask = ~(napX ^ (napX + AW'(1)));
    firstIn = inRange(mode, firstWord, botW, topW, napX, napMask);
    lastIn  = inRange(mode, lastWord, botW, topW, napX, napMask);
  end

endmodule // prot_entry_match

// ---- verification/prot_core_model.sv ----
// Purpose: core pipeline side issuing csr and access requests
// Assumes: requests change at falling mclk, answers read at the next falling edge
// Notes:   idle address and data fields are inverted so stale values never match
module prot_core_model
  import prot_pkg::*;
(
  // clock
  input  wire logic            mclk,
  // csr port
  output logic                 csrValid,
  output logic                 csrWrite,
  output logic [11:0]          csrAddr,
  output logic [XLEN-1:0]      csrWdata,
  output logic [1:0]           csrPriv,
  input  wire logic            csrDone_r,
  input  wire logic            csrIllegal_r,
  input  wire logic [XLEN-1:0] csrRdata_r,
  // access port
  output logic [1:0]           previousPrivilege,
  output logic                 modifyPrivilege,
  output logic                 accValid,
  output logic [1:0]           accType,
  output logic [1:0]           accSize,
  output logic [PA_W-1:0]      accAddr,
  output logic [1:0]           accPriv,
  output logic                 accPtw,
  input  wire logic            accDone_r,
  input  wire logic            accDeny_r,
  input  wire logic [2:0]      faults
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {csrValid, csrWrite, csrAddr, csrWdata, csrPriv} = '0;
    {previousPrivilege, modifyPrivilege, accValid, accType} = '0;
    {accSize, accAddr, accPriv, accPtw} = '0;
  end

  // registers reached only through csr requests
  task automatic csrOp(input logic wr, input logic [11:0] a,
      input logic [XLEN-1:0] d, input logic [1:0] p, output logic dn,
      output logic il, output logic [XLEN-1:0] rd);
    @(negedge mclk);
    {csrValid, csrWrite, csrAddr, csrWdata, csrPriv} = {1'b1, wr, a, d, p};
    @(negedge mclk);
    {dn, il, rd} = {csrDone_r, csrIllegal_r, csrRdata_r};
    {csrValid, csrAddr, csrWdata} = {1'b0, ~a, ~d};
  endtask

  task automatic accOp(input logic [1:0] ty, input logic [1:0] sz,
      input logic [PA_W-1:0] ad, input logic [1:0] pr, input logic ptw,
      input logic mp, output logic dn, output logic dy,
      output logic [2:0] f);
    @(negedge mclk);
    {accValid, accType, accSize, accAddr} = {1'b1, ty, sz, ad};
    {accPriv, accPtw, modifyPrivilege, previousPrivilege} =
      {pr, ptw, mp, PRIV_U};
    @(negedge mclk);
    {dn, dy, f} = {accDone_r, accDeny_r, faults};
    {accValid, accAddr} = {1'b0, ~ad};
  endtask
endmodule // prot_core_model

// ---- verification/physical_memory_protection_unit_test.sv ----
// Purpose: self-checking bench for the protection checker
// Assumes: one idle cycle between requests issued by the core model
// Notes:   six entries programmed, access rows walked in one loop
module physical_memory_protection_unit_test import prot_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, nrst, clkEn, csrValid, csrWrite, csrDone_r, csrIllegal_r;
  logic [11:0] csrAddr;
  logic [63:0] csrWdata, csrRdata_r, rd;
  logic [1:0] csrPriv, previousPrivilege, accType, accSize, accPriv;
  logic modifyPrivilege, accValid, accPtw, accDone_r, accDeny_r, dn, il;
  logic [55:0] accAddr;
  logic [2:0] faults, f;
  int err_total = 0;
  int cmp_count = 0;

  typedef struct packed {
    logic [1:0] ty, sz; logic [55:0] ad; logic [1:0] pr;
    logic ptw, mp, deny;
  } prot_row_t;
  localparam logic [63:0] CFG = 64'h0000_9907_1f14_1b09;
  localparam logic [63:0] AREG [6] = '{64'h400, 64'h1000_01ff,
    64'h0800_0000, 64'h1001_ffff, 64'h1800_01ff, 64'h1c00_01ff};
  prot_row_t rows [18] = '{
    {ACC_LOAD, 2'h3, 56'h0, PRIV_U, 3'b000},
    {ACC_STORE, 2'h3, 56'h0, PRIV_U, 3'b001},
    {ACC_LOAD, 2'h3, 56'hffc, PRIV_U, 3'b001},
    {ACC_LOAD, 2'h0, 56'hfff, PRIV_U, 3'b000},
    {ACC_LOAD, 2'h0, 56'h1000, PRIV_U, 3'b001},
    {ACC_STORE, 2'h3, 56'h4000_0ff8, PRIV_U, 3'b000},
    {ACC_FETCH, 2'h2, 56'h4000_0000, PRIV_U, 3'b001},
    {ACC_FETCH, 2'h2, 56'h4000_1000, PRIV_U, 3'b000},
    {ACC_LOAD, 2'h2, 56'h6000_0000, PRIV_U, 3'b001},
    {ACC_FETCH, 2'h2, 56'h2000_003c, PRIV_U, 3'b000},
    {ACC_FETCH, 2'h2, 56'h2000_0040, PRIV_U, 3'b001},
    {ACC_STORE, 2'h2, 56'h7000_0000, PRIV_M, 3'b001},
    {ACC_LOAD, 2'h2, 56'h7000_0000, PRIV_M, 3'b000},
    {ACC_FETCH, 2'h2, 56'h4000_0000, PRIV_M, 3'b000},
    {ACC_LOAD, 2'h2, 56'h9000_0000, PRIV_S, 3'b001},
    {ACC_LOAD, 2'h2, 56'h9000_0000, PRIV_M, 3'b101},
    {ACC_LOAD, 2'h2, 56'h9000_0000, PRIV_M, 3'b011},
    {ACC_FETCH, 2'h2, 56'h9000_0000, PRIV_M, 3'b010}
  };

  prot_checker u_dut (.mclk, .nrst, .clkEn, .csrValid, .csrWrite,
    .csrAddr, .csrWdata, .csrPriv, .csrDone_r, .csrIllegal_r, .csrRdata_r,
    .previousPrivilege, .modifyPrivilege, .accValid, .accType, .accSize,
    .accAddr, .accPriv, .accPtw, .accDone_r, .accDeny_r,
    .loadFault_r(faults[0]), .storeFault_r(faults[1]),
    .fetchFault_r(faults[2]));
  prot_core_model u_core (.mclk, .csrValid, .csrWrite, .csrAddr,
    .csrWdata, .csrPriv, .csrDone_r, .csrIllegal_r, .csrRdata_r,
    .previousPrivilege, .modifyPrivilege, .accValid, .accType, .accSize,
    .accAddr, .accPriv, .accPtw, .accDone_r, .accDeny_r, .faults);

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic final_report();
    if (err_total == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic checkCsr(input logic [63:0] r, input logic i,
      input logic [63:0] er, input logic ei);
    cmp_count++;
    if (dn !== 1'b1 || i !== ei || r !== er) begin
      err_total++;
      $display("[FAIL] %0t csr answer %h ill %b", $time, r, i);
    end
  endtask

  task automatic checkAcc(input prot_row_t r);
    u_core.accOp(r.ty, r.sz, r.ad, r.pr, r.ptw, r.mp, dn, il, f);
    cmp_count++;
    if (dn !== 1'b1 || il !== r.deny ||
        f !== (r.deny ? 3'b001 << r.ty : 3'b000)) begin
      err_total++;
      $display("[FAIL] %0t access %h deny %b", $time, r.ad, il);
    end
  endtask

  task automatic doReset();
    @(negedge mclk);
    nrst = 1'b0;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    err_total++;
    final_report();
  end

  initial begin
    {nrst, clkEn} = 2'b01;
    doReset();
    u_core.csrOp(1'b0, CSR_CFG_LOW, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, 64'h0, 1'b0);
    for (int i = 0; i < 6; i++)
      u_core.csrOp(1'b1, CSR_ADDR_BASE + 12'(i), AREG[i], PRIV_M, dn, il, rd);
    u_core.csrOp(1'b1, CSR_CFG_LOW, CFG, PRIV_M, dn, il, rd);
    u_core.csrOp(1'b0, CSR_CFG_LOW, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, CFG, 1'b0);
    u_core.csrOp(1'b0, CSR_ADDR_BASE + 12'h1, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, AREG[1], 1'b0);
    foreach (rows[i]) checkAcc(rows[i]);
    u_core.csrOp(1'b1, CSR_ADDR_BASE, 64'h0, PRIV_U, dn, il, rd);
    checkCsr(rd, il, 64'h0, 1'b1);
    u_core.csrOp(1'b0, CSR_ADDR_BASE, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, AREG[0], 1'b0);
    u_core.csrOp(1'b0, CSR_CFG_ODD1, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, 64'h0, 1'b1);
    u_core.csrOp(1'b1, CSR_CFG_ODD3, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, 64'h0, 1'b1);
    u_core.csrOp(1'b1, CSR_CFG_HIGH, '1, PRIV_M, dn, il, rd);
    u_core.csrOp(1'b0, CSR_CFG_HIGH, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, 64'h0, 1'b0);
    u_core.csrOp(1'b1, CSR_ADDR_BASE + 12'h5, 64'h0, PRIV_M, dn, il, rd);
    u_core.csrOp(1'b0, CSR_ADDR_BASE + 12'h5, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, AREG[5], 1'b0);
    u_core.csrOp(1'b1, CSR_CFG_LOW, 64'h0001_0007_1f14_1b09, PRIV_M, dn,
      il, rd);
    u_core.csrOp(1'b0, CSR_CFG_LOW, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, 64'h0001_9907_1f14_1b09, 1'b0);
    doReset();
    u_core.csrOp(1'b0, CSR_CFG_LOW, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, 64'h0, 1'b0);
    checkAcc(rows[1]);
    checkAcc(rows[11] ^ 65'h1);
    clkEn = 1'b0;
    u_core.csrOp(1'b1, CSR_ADDR_BASE, 64'h123, PRIV_M, dn, il, rd);
    clkEn = 1'b1;
    u_core.csrOp(1'b0, CSR_ADDR_BASE, 64'h0, PRIV_M, dn, il, rd);
    checkCsr(rd, il, 64'h0, 1'b0);
    final_report();
  end
endmodule // physical_memory_protection_unit_test
